// ==== riad_host.sv ====
`timescale 1ns/10ps
module riad_host (
    // clock
    input  wire logic                clk,
    // host bus
    output riad_pkg::riad_req_t      req,
    input  wire riad_pkg::riad_rsp_t rsp
);
    initial req = '{1'b1, 1'b1, 1'b1, 19'h0, 32'h0, 4'h0};

    // strobes stay put until ack or error is sampled; no answer in 16 edges gives x
    task automatic access(input logic r, input logic [18:0] a, input logic [31:0] wd,
                          output logic [31:0] d, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b0, 1'b0, r, a, wd, 4'hf};
        @(posedge clk);
        while (rsp.transfer_ack_n !== 1'b0 && rsp.bus_error_n !== 1'b0 && n < 16)
        begin
            n++;
            @(posedge clk);
        end
        d = rsp.rdata;
        e = (n == 16) ? 1'bx : ~rsp.bus_error_n;
        // released lines carry the inverse so a stale value cannot pass
        req <= '{1'b1, 1'b1, ~r, ~a, ~wd, 4'h0};
        @(posedge clk);
        @(posedge clk);
    endtask : access
endmodule : riad_host

// ==== riad_pkg.sv ====
package riad_pkg;

    // host port geometry
    localparam int unsigned ADDR_W      = 19;
    localparam int unsigned CM_IDX_W    = 15;
    localparam int unsigned GROUP_W     = 5;
    localparam int unsigned GROUPS      = 32;
    localparam int unsigned CM_DEPTH    = 32768;
    localparam logic [14:0] CM_LAST_IDX = 15'h7fff;

    // address map
    localparam logic [18:0] CM_LAST     = 19'h1ffff;
    localparam logic [18:0] CML_LAST    = 19'h27fff;
    localparam logic [18:0] DM_LAST     = 19'h2ffff;
    localparam logic [18:0] BEREN_LAST  = 19'h37fff;
    localparam logic [18:0] BERCNT_BASE = 19'h40000;
    localparam logic [18:0] BERCNT_LAST = 19'h401ff;
    localparam logic [18:0] GROUP_BASE  = 19'h40200;
    localparam logic [18:0] GROUP_LAST  = 19'h4027f;
    localparam logic [18:0] ICC_OFS     = 19'h40280;
    localparam logic [18:0] OCC_OFS     = 19'h40284;
    localparam logic [18:0] FILLPAT_OFS = 19'h40288;
    localparam logic [18:0] FILLEN_OFS  = 19'h4028c;

    // register reset values and fields
    localparam logic [31:0] GROUP_RST   = 32'h000c000c;
    localparam logic [31:0] ICC_RST     = 32'h000000db;
    localparam logic [31:0] OCC_RST     = 32'h060d1c3c;
    localparam logic [31:0] FILLPAT_RST = 32'h00000000;
    localparam int unsigned FILLEN_START_BIT = 0;

    // timing
    localparam int unsigned REF_CLK_MHZ      = 200;
    localparam int unsigned INIT_TIME_US     = 1000;
    localparam int unsigned INIT_CYCLES_DEF  = INIT_TIME_US * REF_CLK_MHZ;
    localparam int unsigned INIT_CNT_W       = 18;
    localparam int unsigned MCLK_LOSS_NS     = 320;
    localparam int unsigned MCLK_LOSS_CYCLES = MCLK_LOSS_NS * REF_CLK_MHZ / 1000;
    localparam logic [6:0]  MCLK_LOSS_LAST   = 7'(MCLK_LOSS_CYCLES - 1);

    typedef enum logic [3:0] {
        REGION_CM      = 4'b0000,
        REGION_CM_LOW  = 4'b0001,
        REGION_DM      = 4'b0010,
        REGION_BER_EN  = 4'b0011,
        REGION_BER_CNT = 4'b0100,
        REGION_GROUP   = 4'b0101,
        REGION_ICC     = 4'b0110,
        REGION_OCC     = 4'b0111,
        REGION_FILLPAT = 4'b1000,
        REGION_FILLEN  = 4'b1001,
        REGION_UNUSED  = 4'b1010
    } riad_region_e_t;

    typedef enum logic [1:0] {
        INIT_WAIT  = 2'b00,
        INIT_CLEAR = 2'b01,
        INIT_HOLD  = 2'b10,
        INIT_READY = 2'b11
    } riad_init_e_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } riad_bus_e_t;

    typedef struct packed {
        logic        cs_n;
        logic        ds_n;
        logic        rd;
        logic [18:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } riad_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        data_oe;
        logic        transfer_ack_n;
        logic        bus_error_n;
        logic        wait_n;
        logic        ctrl_oe;
    } riad_rsp_t;

    typedef struct packed {
        logic [31:0] line_a;
        logic [31:0] line_b;
        logic [31:0] line_c;
        logic [31:0] line_d;
    } riad_stream_oe_t;

endpackage : riad_pkg

// ==== riad_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// - reset high holds host port in reset asynchronously
// - reset high tristates all output stream lines
// - reset high loads every register default
// - reset high clears every internal counter
// - initialization ends about 1 ms after clock
// - init clears connection memory without host
// - group control registers reset to 000c000c
// - input clock control resets to 0db
// - output clock control resets to 060d1c3c
// - timing clocks run 65, 32, 16, 8 MHz
// - no master clock: every access bus errors
// - data memory read only, writes bus error
// - unused address ranges answer bus error
// - decode ber enable memory and ber counters
// - decode connection memory and its low window
// - each access ends with ack or error
// - refused writes leave all storage unchanged
module riad_top #(
    parameter int unsigned INIT_CYCLES = riad_pkg::INIT_CYCLES_DEF
) (
    // clock and power-on reset
    input  wire logic                       REF_CLK,
    input  wire logic                       RST,
    // master timing and output drive
    input  wire logic                       MASTER_CLOCK_IN,
    input  wire logic                       OUTPUT_DRIVE_ENABLE,
    // host port
    input  wire riad_pkg::riad_req_t        HOST_REQ,
    output riad_pkg::riad_rsp_t             HOST_RSP,
    // stream drive, timing and access region outputs
    output riad_pkg::riad_stream_oe_t       STREAM_OE,
    output logic [3:0]                      TIMING_CLOCK_OUT,
    output riad_pkg::riad_region_e_t        ACCESS_REGION
);

    localparam logic [17:0] INIT_LAST = 18'(INIT_CYCLES - 1);

    logic                          mclk_q;
    logic                          mclk_prev_q;
    logic [6:0]                    loss_cnt_q;
    logic                          mclk_ok_q;
    logic [2:0]                    mdiv_q;
    logic [3:0]                    tco_q;
    riad_pkg::riad_init_e_t        init_q;
    logic [17:0]                   init_cnt_q;
    logic                          init_ready;
    logic                          fill_busy_q;
    logic [14:0]                   fill_idx_q;
    logic [31:0]                   group_q [riad_pkg::GROUPS];
    logic [31:0]                   icc_q;
    logic [31:0]                   occ_q;
    logic [31:0]                   fillpat_q;
    logic [31:0]                   cm_mem [riad_pkg::CM_DEPTH];
    logic                          cm_we;
    logic [14:0]                   cm_widx;
    logic [31:0]                   cm_wdata;
    logic [14:0]                   host_idx;
    logic [31:0]                   cm_old;
    logic                          strobe;
    logic                          take;
    logic                          err;
    logic                          host_wr;
    riad_pkg::riad_region_e_t      region;
    logic [31:0]                   rd_mux;
    riad_pkg::riad_bus_e_t         bus_q;
    logic                          ack_n_q;
    logic                          bus_error_n_n_q;
    logic [31:0]                   rdata_q;
    riad_pkg::riad_region_e_t      region_q;
    logic                          stream_en_q;

    function automatic riad_pkg::riad_region_e_t decode(input logic [18:0] a);
        if (a <= riad_pkg::CM_LAST)
            return riad_pkg::REGION_CM;
        else if (a <= riad_pkg::CML_LAST)
            return riad_pkg::REGION_CM_LOW;
        else if (a <= riad_pkg::DM_LAST)
            return riad_pkg::REGION_DM;
        else if (a <= riad_pkg::BEREN_LAST)
            return riad_pkg::REGION_BER_EN;
        else if (a >= riad_pkg::BERCNT_BASE && a <= riad_pkg::BERCNT_LAST)
            return riad_pkg::REGION_BER_CNT;
        else if (a >= riad_pkg::GROUP_BASE && a <= riad_pkg::GROUP_LAST)
            return riad_pkg::REGION_GROUP;
        else if (a[18:2] == riad_pkg::ICC_OFS[18:2])
            return riad_pkg::REGION_ICC;
        else if (a[18:2] == riad_pkg::OCC_OFS[18:2])
            return riad_pkg::REGION_OCC;
        else if (a[18:2] == riad_pkg::FILLPAT_OFS[18:2])
            return riad_pkg::REGION_FILLPAT;
        else if (a[18:2] == riad_pkg::FILLEN_OFS[18:2])
            return riad_pkg::REGION_FILLEN;
        else
            return riad_pkg::REGION_UNUSED;
    endfunction : decode

    function automatic logic [4:0] group_index(input logic [18:0] a);
        logic [18:0] ofs;
        ofs = a - riad_pkg::GROUP_BASE;
        return ofs[6:2];
    endfunction : group_index

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8*i +: 8] = nw[8*i +: 8];
        return r;
    endfunction : be_merge

    // master clock presence: no edge for a while means the clock is gone
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            mclk_q      <= 1'b0;
            mclk_prev_q <= 1'b0;
            loss_cnt_q  <= 7'h00;
            mclk_ok_q   <= 1'b0;
        end
        else
        begin
            mclk_q      <= MASTER_CLOCK_IN;
            mclk_prev_q <= mclk_q;
            if (mclk_q != mclk_prev_q)
            begin
                loss_cnt_q <= 7'h00;
                mclk_ok_q  <= 1'b1;
            end
            else if (loss_cnt_q == riad_pkg::MCLK_LOSS_LAST)
                mclk_ok_q  <= 1'b0;
            else
                loss_cnt_q <= loss_cnt_q + 7'h01;
        end
    end

    // timing clocks: the master clock and three divided copies, assumed at 65 MHz
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            mdiv_q <= 3'h0;
            tco_q  <= 4'h0;
        end
        else
        begin
            if (mclk_q && !mclk_prev_q)
                mdiv_q <= mdiv_q + 3'h1;
            tco_q <= {mdiv_q[2], mdiv_q[1], mdiv_q[0], mclk_q};
        end
    end

    // post-reset initialization waits for the master clock first
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            init_q     <= riad_pkg::INIT_WAIT;
            init_cnt_q <= 18'h00000;
        end
        else
        begin
            unique case (init_q)
                riad_pkg::INIT_WAIT:
                begin
                    if (mclk_ok_q)
                        init_q <= riad_pkg::INIT_CLEAR;
                end
                riad_pkg::INIT_CLEAR:
                begin
                    init_cnt_q <= init_cnt_q + 18'h00001;
                    if (init_cnt_q[14:0] == riad_pkg::CM_LAST_IDX)
                        init_q <= riad_pkg::INIT_HOLD;
                end
                riad_pkg::INIT_HOLD:
                begin
                    init_cnt_q <= init_cnt_q + 18'h00001;
                    if (init_cnt_q >= INIT_LAST)
                        init_q <= riad_pkg::INIT_READY;
                end
                riad_pkg::INIT_READY:
                begin
                    init_q <= riad_pkg::INIT_READY;
                end
            endcase
        end
    end

    assign init_ready = (init_q == riad_pkg::INIT_READY);

    // host access decode
    assign strobe   = !HOST_REQ.cs_n && !HOST_REQ.ds_n;
    assign take     = (bus_q == riad_pkg::BUS_IDLE) && strobe;
    assign region   = decode(HOST_REQ.addr);
    assign host_idx = (region == riad_pkg::REGION_CM) ? HOST_REQ.addr[16:2] : HOST_REQ.addr[14:0];
    assign cm_old   = cm_mem[host_idx];

    always_comb
    begin
        err = 1'b0;
        if (!mclk_ok_q)
            err = 1'b1;
        if (!init_ready)
            err = 1'b1;
        if (region == riad_pkg::REGION_UNUSED)
            err = 1'b1;
        if (region == riad_pkg::REGION_DM && !HOST_REQ.rd)
            err = 1'b1;
        // a block fill owns the memory write port, so host writes to it get a bus error
        if (fill_busy_q && !HOST_REQ.rd &&
            (region == riad_pkg::REGION_CM || region == riad_pkg::REGION_CM_LOW))
            err = 1'b1;
    end

    assign host_wr = take && !err && !HOST_REQ.rd;

    always_comb
    begin
        unique case (region)
            riad_pkg::REGION_CM:      rd_mux = cm_old;
            riad_pkg::REGION_CM_LOW:  rd_mux = {24'h000000, cm_old[7:0]};
            riad_pkg::REGION_GROUP:   rd_mux = group_q[group_index(HOST_REQ.addr)];
            riad_pkg::REGION_ICC:     rd_mux = icc_q;
            riad_pkg::REGION_OCC:     rd_mux = occ_q;
            riad_pkg::REGION_FILLPAT: rd_mux = fillpat_q;
            riad_pkg::REGION_FILLEN:  rd_mux = {31'h00000000, fill_busy_q};
            default:                  rd_mux = 32'h00000000;
        endcase
    end

    // one memory write port: init clear, then block fill, then host
    always_comb
    begin
        cm_we    = 1'b0;
        cm_widx  = 15'h0000;
        cm_wdata = 32'h00000000;
        if (init_q == riad_pkg::INIT_CLEAR)
        begin
            cm_we    = 1'b1;
            cm_widx  = init_cnt_q[14:0];
        end
        else if (fill_busy_q)
        begin
            cm_we    = 1'b1;
            cm_widx  = fill_idx_q;
            cm_wdata = fillpat_q;
        end
        else if (host_wr && region == riad_pkg::REGION_CM)
        begin
            cm_we    = 1'b1;
            cm_widx  = host_idx;
            cm_wdata = be_merge(cm_old, HOST_REQ.wdata, HOST_REQ.be);
        end
        else if (host_wr && region == riad_pkg::REGION_CM_LOW)
        begin
            cm_we    = 1'b1;
            cm_widx  = host_idx;
            cm_wdata = be_merge(cm_old, {24'h000000, HOST_REQ.wdata[7:0]}, {3'h0, HOST_REQ.be[0]});
        end
    end

    // contents come from the clear sequence, so the array needs no reset
    always_ff @(posedge REF_CLK)
    begin
        if (cm_we)
            cm_mem[cm_widx] <= cm_wdata;
    end

    // block fill started by software
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            fill_busy_q <= 1'b0;
            fill_idx_q  <= 15'h0000;
        end
        else if (fill_busy_q)
        begin
            fill_idx_q <= fill_idx_q + 15'h0001;
            if (fill_idx_q == riad_pkg::CM_LAST_IDX)
                fill_busy_q <= 1'b0;
        end
        else if (host_wr && region == riad_pkg::REGION_FILLEN && HOST_REQ.be[0] &&
                 HOST_REQ.wdata[riad_pkg::FILLEN_START_BIT])
        begin
            fill_busy_q <= 1'b1;
            fill_idx_q  <= 15'h0000;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            for (int g = 0; g < riad_pkg::GROUPS; g++)
                group_q[g] <= riad_pkg::GROUP_RST;
        end
        else if (host_wr && region == riad_pkg::REGION_GROUP)
            group_q[group_index(HOST_REQ.addr)] <= be_merge(rd_mux, HOST_REQ.wdata, HOST_REQ.be);
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            icc_q     <= riad_pkg::ICC_RST;
            occ_q     <= riad_pkg::OCC_RST;
            fillpat_q <= riad_pkg::FILLPAT_RST;
        end
        else if (host_wr)
        begin
            if (region == riad_pkg::REGION_ICC)
                icc_q <= be_merge(icc_q, HOST_REQ.wdata, HOST_REQ.be);
            if (region == riad_pkg::REGION_OCC)
                occ_q <= be_merge(occ_q, HOST_REQ.wdata, HOST_REQ.be);
            if (region == riad_pkg::REGION_FILLPAT)
                fillpat_q <= be_merge(fillpat_q, HOST_REQ.wdata, HOST_REQ.be);
        end
    end

    // bus cycle: answer one edge after the strobe, hold until strobe drops
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            bus_q    <= riad_pkg::BUS_IDLE;
            ack_n_q  <= 1'b1;
            bus_error_n_n_q <= 1'b1;
            rdata_q  <= 32'h00000000;
            region_q <= riad_pkg::REGION_UNUSED;
        end
        else
        begin
            unique case (bus_q)
                riad_pkg::BUS_IDLE:
                begin
                    if (take)
                    begin
                        bus_q    <= riad_pkg::BUS_DONE;
                        ack_n_q  <= err;
                        bus_error_n_n_q <= !err;
                        rdata_q  <= err ? 32'h00000000 : rd_mux;
                        region_q <= region;
                    end
                end
                riad_pkg::BUS_DONE:
                begin
                    if (HOST_REQ.ds_n || HOST_REQ.cs_n)
                    begin
                        bus_q    <= riad_pkg::BUS_IDLE;
                        ack_n_q  <= 1'b1;
                        bus_error_n_n_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // streams stay off until init is done and the drive pin allows them
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            stream_en_q <= 1'b0;
        else
            stream_en_q <= init_ready && OUTPUT_DRIVE_ENABLE;
    end

    assign HOST_RSP.rdata          = rdata_q;
    assign HOST_RSP.data_oe        = !RST && !HOST_REQ.cs_n && HOST_REQ.rd && (bus_q == riad_pkg::BUS_DONE);
    assign HOST_RSP.transfer_ack_n = ack_n_q;
    assign HOST_RSP.bus_error_n    = bus_error_n_n_q;
    assign HOST_RSP.wait_n         = RST || !take;
    assign HOST_RSP.ctrl_oe        = !RST && !HOST_REQ.cs_n;
    assign STREAM_OE               = {128{stream_en_q}};
    assign TIMING_CLOCK_OUT        = tco_q;
    assign ACCESS_REGION           = region_q;

    sequence access_start_s;
        take;
    endsequence

    sequence answer_s;
        (ack_n_q != bus_error_n_n_q) && (bus_q == riad_pkg::BUS_DONE);
    endsequence

    port_reset_a: assert property (@(posedge REF_CLK) RST |-> HOST_RSP.transfer_ack_n && HOST_RSP.bus_error_n
        && !HOST_RSP.ctrl_oe && !HOST_RSP.data_oe) else $error("host port active in reset");
    stream_off_a: assert property (@(posedge REF_CLK) disable iff (RST) !init_ready |=> STREAM_OE == '0)
        else $error("streams driven before init done");
    reg_defaults_a: assert property (@(posedge REF_CLK) $fell(RST) |-> group_q[31] == riad_pkg::GROUP_RST
        && icc_q == riad_pkg::ICC_RST && occ_q == riad_pkg::OCC_RST) else $error("bad register default");
    count_clear_a: assert property (@(posedge REF_CLK) $fell(RST) |-> init_cnt_q == 18'h0 && mdiv_q == 3'h0
        && fill_idx_q == 15'h0) else $error("counter not cleared");
    init_time_a: assert property (@(posedge REF_CLK) disable iff (RST) $rose(init_ready) |->
        $past(init_cnt_q) == INIT_LAST) else $error("init length wrong");
    clear_zero_a: assert property (@(posedge REF_CLK) disable iff (RST) init_q == riad_pkg::INIT_CLEAR |->
        cm_we && cm_wdata == 32'h0 && cm_widx == init_cnt_q[14:0]) else $error("clear write wrong");
    no_clock_a: assert property (@(posedge REF_CLK) disable iff (RST) access_start_s ##0 !mclk_ok_q |=>
        !HOST_RSP.bus_error_n && HOST_RSP.transfer_ack_n) else $error("no bus error without clock");
    dm_write_a: assert property (@(posedge REF_CLK) disable iff (RST) take && region == riad_pkg::REGION_DM
        && !HOST_REQ.rd |=> !bus_error_n_n_q) else $error("data memory write accepted");
    unused_err_a: assert property (@(posedge REF_CLK) disable iff (RST) take
        && region == riad_pkg::REGION_UNUSED |=> !bus_error_n_n_q) else $error("unused access accepted");
    answer_held_a: assert property (@(posedge REF_CLK) disable iff (RST) access_start_s |=> answer_s
        ##1 (answer_s or (bus_q == riad_pkg::BUS_IDLE))) else $error("access not answered");
    refused_write_a: assert property (@(posedge REF_CLK) disable iff (RST) take && err && init_ready
        && !fill_busy_q |-> !cm_we) else $error("refused write stored");
    init_reject_a: assert property (@(posedge REF_CLK) disable iff (RST) access_start_s ##0 !init_ready |=>
        !bus_error_n_n_q) else $error("access before init accepted");
    group_sel_a: assert property (@(posedge REF_CLK) disable iff (RST) host_wr && region == riad_pkg::REGION_GROUP
        && HOST_REQ.be == 4'hf |=> group_q[$past(HOST_REQ.addr[6:2])] == $past(HOST_REQ.wdata))
        else $error("group register not selected");
    region_map_a: assert property (@(posedge REF_CLK) disable iff (RST) take && HOST_REQ.addr[18:15] == 4'h6
        |=> region_q == riad_pkg::REGION_BER_EN) else $error("ber enable decode wrong");

endmodule : riad_top

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned INIT = 33000;
    logic                       ref_clk, rst, mclk, mclk_on, output_drive_enable;
    riad_pkg::riad_req_t        req;
    riad_pkg::riad_rsp_t        rsp;
    riad_pkg::riad_stream_oe_t  soe;
    logic [3:0]                 tco, tp;
    riad_pkg::riad_region_e_t   region;
    int                         errors, num_checks, c0, c3, a0, a3;
    logic [18:0]                bad_addr [4] = '{19'h38000, 19'h3fffc, 19'h40290, 19'h7fffc};

    riad_host host (.clk(ref_clk), .req(req), .rsp(rsp));
    riad_top #(.INIT_CYCLES(INIT)) dut (.REF_CLK(ref_clk), .RST(rst), .MASTER_CLOCK_IN(mclk),
        .OUTPUT_DRIVE_ENABLE(output_drive_enable), .HOST_REQ(req), .HOST_RSP(rsp), .STREAM_OE(soe),
        .TIMING_CLOCK_OUT(tco), .ACCESS_REGION(region));

    initial forever #2.5 ref_clk = ~ref_clk;
    // master clock free of the reference phase; stops when mclk_on is low
    initial forever #7.63 mclk = mclk_on ? ~mclk : mclk;

    always @(posedge ref_clk)
    begin
        tp <= tco;
        c0 <= c0 + int'(tco[0] & ~tp[0]);
        c3 <= c3 + int'(tco[3] & ~tp[3]);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rw(input logic r, input logic [18:0] a, input logic [31:0] wd,
                      input logic eb, input logic [31:0] ed);
        logic [31:0] d;
        logic        e;
        host.access(r, a, wd, d, e);
        chk({31'h0, e}, {31'h0, eb});
        if (r && !eb)
            chk(d, ed);
    endtask : rw

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic boot();
        repeat (16) @(posedge ref_clk);
        chk({25'h0, |soe, rsp.transfer_ack_n, rsp.bus_error_n, |tco, rsp.ctrl_oe, rsp.data_oe, rsp.wait_n},
            32'h31);
        rst <= 1'b0;
        rw(1'b1, riad_pkg::ICC_OFS, 32'h0, 1'b1, 32'h0);
        mclk_on = 1'b1;
        repeat (INIT - 2000) @(posedge ref_clk);
        rw(1'b1, riad_pkg::ICC_OFS, 32'h0, 1'b1, 32'h0);
        repeat (2200) @(posedge ref_clk);
    endtask : boot

    initial
    begin
        ref_clk = 0;
        rst = 1;
        mclk = 0;
        mclk_on = 0;
        output_drive_enable = 0;
        errors = 0;
        num_checks = 0;
        c0 = 0;
        c3 = 0;
        tp = 0;
        boot();
        rw(1'b1, riad_pkg::GROUP_BASE, 32'h0, 1'b0, riad_pkg::GROUP_RST);
        rw(1'b1, 19'h4027c, 32'h0, 1'b0, riad_pkg::GROUP_RST);
        rw(1'b1, riad_pkg::ICC_OFS, 32'h0, 1'b0, riad_pkg::ICC_RST);
        rw(1'b1, riad_pkg::OCC_OFS, 32'h0, 1'b0, riad_pkg::OCC_RST);
        rw(1'b1, 19'h00000, 32'h0, 1'b0, 32'h0);
        rw(1'b1, 19'h1fffc, 32'h0, 1'b0, 32'h0);
        rw(1'b0, 19'h40214, 32'h12345678, 1'b0, 32'h0);
        rw(1'b1, 19'h40214, 32'h0, 1'b0, 32'h12345678);
        rw(1'b1, 19'h40210, 32'h0, 1'b0, riad_pkg::GROUP_RST);
        rw(1'b0, 19'h1fffc, 32'ha5a55a5a, 1'b0, 32'h0);
        rw(1'b1, 19'h1fffc, 32'h0, 1'b0, 32'ha5a55a5a);
        rw(1'b0, 19'h20000, 32'h000000c3, 1'b0, 32'h0);
        rw(1'b1, 19'h00000, 32'h0, 1'b0, 32'h000000c3);
        rw(1'b0, 19'h28000, 32'hffffffff, 1'b1, 32'h0);
        rw(1'b1, 19'h2fffc, 32'h0, 1'b0, 32'h0);
        foreach (bad_addr[i])
        begin
            rw(1'b0, bad_addr[i], 32'hffffffff, 1'b1, 32'h0);
            rw(1'b1, bad_addr[i], 32'h0, 1'b1, 32'h0);
        end
        rw(1'b1, riad_pkg::OCC_OFS, 32'h0, 1'b0, riad_pkg::OCC_RST);
        rw(1'b1, 19'h00000, 32'h0, 1'b0, 32'h000000c3);
        rw(1'b0, 19'h30000, 32'h1, 1'b0, 32'h0);
        chk({28'h0, region}, {28'h0, riad_pkg::REGION_BER_EN});
        rw(1'b1, 19'h401fc, 32'h0, 1'b0, 32'h0);
        chk({28'h0, region}, {28'h0, riad_pkg::REGION_BER_CNT});
        a0 = c0;
        a3 = c3;
        repeat (1600) @(posedge ref_clk);
        a0 = c0 - a0;
        a3 = c3 - a3;
        chk({31'h0, a3 > 40 && a0 >= 8 * a3 - 8 && a0 <= 8 * a3 + 8}, 32'h1);
        output_drive_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({31'h0, &soe}, 32'h1);
        mclk_on = 1'b0;
        repeat (100) @(posedge ref_clk);
        rw(1'b1, riad_pkg::ICC_OFS, 32'h0, 1'b1, 32'h0);
        #1 rst = 1'b1;
        #1 chk({30'h0, |soe, |tco}, 32'h0);
        output_drive_enable <= 1'b0;
        boot();
        rw(1'b1, 19'h40214, 32'h0, 1'b0, riad_pkg::GROUP_RST);
        final_report();
    end

    // the run needs about 68k cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        final_report();
    end
endmodule : tb_top
